// ==== verilog/phy_mode_pkg.sv ====
// constants, layouts and carriers for the power and mode configuration registers
// Overview of operation
// RULE1: while sleep mode is on and the pulse enable bit 15 is set, a single link pulse goes out every interval, else none.
// RULE2: the transmit interval code reads 00 as one second, 01 as 768 ms, 10 as 512 ms and 11 as 256 ms.
// RULE3: in sleep with single-pulse wake (bit 12) set, one received link pulse wakes the device.
// RULE4: with single-pulse wake clear, two received pulses within the window of bits 11:10 (64, 256, 512 ms, one second) wake it.
// RULE5: bit 2 enables green ethernet operation when set and disables it when clear, resetting to zero.
// RULE6: in sleep with bit 1 set, the crossover time grows by 2976 ms, otherwise bit 1 adds nothing.
// RULE7: with auto crossover on and speed forced, bit 0 (reset one) adds 1984 ms to the crossover time; here it adds nothing while RULE6 applies.
// RULE8: mode bit 13 turns sleep mode on when one and off when zero, resetting to zero.
// RULE9: bit 9 echoes received packets back out, only in the reduced interface mode, even while isolated.
// RULE10: mode bit 6 picks the alternate interrupt system when one and the primary one when zero.
// RULE11: the read-only energy bit falls after 256 ms without line energy, is one after hardware reset and survives soft reset.
// RULE12: read-only bit 14 shows the interface kind, zero for full and one for reduced, reset from its strap.
// RULE13: bits 7:5 hold a writable three-bit transceiver mode taken from the mode straps at reset.
// RULE14: bits 4:0 hold a writable station address, loaded from the address strap, used for frame match and scrambler seed.
// RULE15: reserved read-only bits read as zero and ignore writes.
package phy_mode_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PERIOD_NS  = 1000000;
  localparam int MS_CYCLES     = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int IVW           = 10;

  localparam logic [IVW-1:0] IV_1000_MS = 10'h3e8;
  localparam logic [IVW-1:0] IV_768_MS  = 10'h300;
  localparam logic [IVW-1:0] IV_512_MS  = 10'h200;
  localparam logic [IVW-1:0] IV_256_MS  = 10'h100;
  localparam logic [IVW-1:0] IV_64_MS   = 10'h040;
  localparam logic [IVW-1:0] ENERGY_TIMEOUT_MS = IV_256_MS;

  localparam logic [11:0] XOVER_SLEEP_MS  = 12'hba0;
  localparam logic [11:0] XOVER_MANUAL_MS = 12'h7c0;
  localparam logic [11:0] XOVER_NONE_MS   = 12'h000;

  localparam logic [4:0] ADDR_SLEEP_CFG = 5'h10;
  localparam logic [4:0] ADDR_MODE_CS   = 5'h11;
  localparam logic [4:0] ADDR_SPECIAL   = 5'h12;

  // sleep / pulse / green configuration
  localparam int B_TX_NLP_EN   = 15;
  localparam int F_TX_IV_HI    = 14;
  localparam int F_TX_IV_LO    = 13;
  localparam int B_SINGLE_WAKE = 12;
  localparam int F_RX_IV_HI    = 11;
  localparam int F_RX_IV_LO    = 10;
  localparam int B_GREEN       = 2;
  localparam int B_XOVER_SLEEP = 1;
  localparam int B_XOVER_MAN   = 0;
  // mode control / status
  localparam int B_SLEEP_EN    = 13;
  localparam int B_ECHO        = 9;
  localparam int B_ALT_IRQ     = 6;
  localparam int B_ENERGY      = 1;
  localparam int B_MODE_SPARE  = 0;
  // special modes
  localparam int B_IF_KIND     = 14;
  localparam int F_MODE_HI     = 7;
  localparam int F_MODE_LO     = 5;
  localparam int F_ADDR_HI     = 4;
  localparam int F_ADDR_LO     = 0;

  localparam logic       RST_XOVER_MAN  = 1'b1;
  localparam logic       RST_ENERGY     = 1'b1;
  localparam logic [1:0] STRAP_SETTLE   = 2'h2;

  typedef struct packed {
    logic [4:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       sleep_mode_enable;
    logic       green_ethernet_enable;
    logic       remote_echo_enable;
    logic       alternate_irq_select;
    logic       interface_kind;
    logic [2:0] xcvr_mode;
    logic [4:0] station_address;
  } ctrl_t;
endpackage

// ==== verilog/ms_interval_timer.sv ====
// millisecond interval timer that pulses once per elapsed interval
`timescale 1ns/1ps
module ms_interval_timer #(
  parameter int W = 10
) (
  input  wire logic         clock,
  input  wire logic         rstn,
  input  wire logic         tick,
  input  wire logic         run,
  input  wire logic [W-1:0] limit,
  output logic              expired
);
  logic [W-1:0] cnt_r;

  initial begin
    if (W < 2) $error("timer width too small");
  end

  // dropping run restarts the interval, so a fresh window always starts at zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r   <= '0;
      expired <= 1'b0;
    end else if (!run) begin
      cnt_r   <= '0;
      expired <= 1'b0;
    end else if (tick) begin
      if (cnt_r >= limit - W'(1)) begin
        cnt_r   <= '0;
        expired <= 1'b1;
      end else begin
        cnt_r   <= cnt_r + W'(1);
        expired <= 1'b0;
      end
    end else begin
      expired <= 1'b0;
    end
  end
endmodule

// ==== verilog/phy_power_mode_config_regs.sv ====
// power, mode and sleep-pulse configuration registers with their small engines
`timescale 1ns/1ps
module phy_power_mode_config_regs #(
  parameter int MS_CYCLES = phy_mode_pkg::MS_CYCLES
) (
  input  wire logic                   clock,
  input  wire logic                   rstn,
  input  wire logic                   soft_reset,
  input  wire phy_mode_pkg::reg_req_t req,
  output logic [15:0]                 rdata,
  output logic                        rvalid,
  input  wire logic                   energy_pin,
  input  wire logic                   rx_nlp,
  input  wire logic                   auto_mdix_en,
  input  wire logic                   speed_forced,
  input  wire logic                   reduced_interface_strap,
  input  wire logic [2:0]             mode_strap,
  input  wire logic [4:0]             address_strap,
  output phy_mode_pkg::ctrl_t         ctrl,
  output logic                        tx_nlp,
  output logic                        sleep_wake,
  output logic [11:0]                 xover_extend_ms
);
  localparam int TW = phy_mode_pkg::IVW;

  initial begin
    if (MS_CYCLES < 2) $error("millisecond divider too short");
  end

  // storage
  logic [15:0] cfg_r;
  logic        sleep_en_r;
  logic        echo_r;
  logic        alt_irq_r;
  logic        spare_r;
  logic        energy_r;
  logic        if_kind_r;
  logic [2:0]  mode_r;
  logic [4:0]  addr_r;
  logic        armed_r;
  logic [31:0] div_r;
  logic        tick_r;
  logic [1:0]  strap_cnt_r;
  logic [8:0]  strap_s1_r;
  logic [8:0]  strap_s2_r;
  logic        energy_s1_r;
  logic        energy_s2_r;
  logic [TW-1:0] tx_iv;
  logic [TW-1:0] rx_iv;
  logic        rx_expired;
  logic        energy_expired;
  logic        wr_cfg;
  logic        wr_mode;
  logic        wr_spec;

  assign wr_cfg  = req.wr && (req.addr == phy_mode_pkg::ADDR_SLEEP_CFG);
  assign wr_mode = req.wr && (req.addr == phy_mode_pkg::ADDR_MODE_CS);
  assign wr_spec = req.wr && (req.addr == phy_mode_pkg::ADDR_SPECIAL);

  // pin synchronisers
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_s1_r  <= '0;
      strap_s2_r  <= '0;
      energy_s1_r <= 1'b0;
      energy_s2_r <= 1'b0;
    end else begin
      strap_s1_r  <= {reduced_interface_strap, mode_strap, address_strap};
      strap_s2_r  <= strap_s1_r;
      energy_s1_r <= energy_pin;
      energy_s2_r <= energy_s1_r;
    end
  end

  // millisecond enable; shared by all timers to keep their counters small
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else if (div_r >= 32'(MS_CYCLES - 1)) begin
      div_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 32'h1;
      tick_r <= 1'b0;
    end
  end

  // soft-reset-immune configuration word; reserved bits never store
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_r <= '0;
      cfg_r[phy_mode_pkg::B_XOVER_MAN] <= phy_mode_pkg::RST_XOVER_MAN;
    end else if (wr_cfg) begin
      cfg_r[15:10] <= req.wdata[15:10];
      cfg_r[2:0]   <= req.wdata[2:0]; // RULE5
    end
  end

  // mode control bits are cleared by soft reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sleep_en_r <= 1'b0;
      echo_r     <= 1'b0;
      alt_irq_r  <= 1'b0;
      spare_r    <= 1'b0;
    end else if (soft_reset) begin
      sleep_en_r <= 1'b0;
      echo_r     <= 1'b0;
      alt_irq_r  <= 1'b0;
      spare_r    <= 1'b0;
    end else if (wr_mode) begin
      sleep_en_r <= req.wdata[phy_mode_pkg::B_SLEEP_EN]; // RULE8
      echo_r     <= req.wdata[phy_mode_pkg::B_ECHO];
      alt_irq_r  <= req.wdata[phy_mode_pkg::B_ALT_IRQ]; // RULE10
      spare_r    <= req.wdata[phy_mode_pkg::B_MODE_SPARE];
    end
  end

  // energy status: presence sets, 256 ms of silence clears, soft reset ignored
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      energy_r <= phy_mode_pkg::RST_ENERGY;
    end else if (energy_s2_r) begin
      energy_r <= 1'b1; // RULE11
    end else if (energy_expired) begin
      energy_r <= 1'b0; // RULE11
    end
  end

  // straps are caught once the synchronisers have settled after release
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      strap_cnt_r <= '0;
      if_kind_r   <= 1'b0;
      mode_r      <= '0;
      addr_r      <= '0;
    end else if (strap_cnt_r != 2'h3) begin
      strap_cnt_r <= strap_cnt_r + 2'h1;
      if (strap_cnt_r == phy_mode_pkg::STRAP_SETTLE) begin
        if_kind_r <= strap_s2_r[8]; // RULE12
        mode_r    <= strap_s2_r[7:5]; // RULE13
        addr_r    <= strap_s2_r[4:0]; // RULE14
      end
    end else if (wr_spec) begin
      mode_r <= req.wdata[phy_mode_pkg::F_MODE_HI:phy_mode_pkg::F_MODE_LO]; // RULE13
      addr_r <= req.wdata[phy_mode_pkg::F_ADDR_HI:phy_mode_pkg::F_ADDR_LO]; // RULE14
    end
  end

  // read port: one cycle latency, reserved and unmapped bits read zero
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rdata  <= '0;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      rdata  <= '0;
      if (req.rd) begin
        case (req.addr)
          phy_mode_pkg::ADDR_SLEEP_CFG: begin
            rdata <= {cfg_r[15:10], 7'h00, cfg_r[2:0]}; // RULE15
          end
          phy_mode_pkg::ADDR_MODE_CS: begin
            rdata <= {2'h0, sleep_en_r, 3'h0, echo_r, 2'h0, alt_irq_r, 4'h0,
                      energy_r, spare_r}; // RULE15
          end
          phy_mode_pkg::ADDR_SPECIAL: begin
            rdata <= {1'b0, if_kind_r, 6'h00, mode_r, addr_r}; // RULE15
          end
          default: begin
            rdata <= '0;
          end
        endcase
      end
    end
  end

  // interval decoding
  always_comb begin
    case (cfg_r[phy_mode_pkg::F_TX_IV_HI:phy_mode_pkg::F_TX_IV_LO])
      2'h0:    tx_iv = phy_mode_pkg::IV_1000_MS; // RULE2
      2'h1:    tx_iv = phy_mode_pkg::IV_768_MS;
      2'h2:    tx_iv = phy_mode_pkg::IV_512_MS;
      default: tx_iv = phy_mode_pkg::IV_256_MS;
    endcase
    case (cfg_r[phy_mode_pkg::F_RX_IV_HI:phy_mode_pkg::F_RX_IV_LO])
      2'h0:    rx_iv = phy_mode_pkg::IV_64_MS; // RULE4
      2'h1:    rx_iv = phy_mode_pkg::IV_256_MS;
      2'h2:    rx_iv = phy_mode_pkg::IV_512_MS;
      default: rx_iv = phy_mode_pkg::IV_1000_MS;
    endcase
  end

  // single link pulse per interval while asleep
  ms_interval_timer #(.W(TW)) u_tx_timer (
    .clock   (clock),
    .rstn    (rstn),
    .tick    (tick_r),
    .run     (sleep_en_r && cfg_r[phy_mode_pkg::B_TX_NLP_EN]), // RULE1
    .limit   (tx_iv),
    .expired (tx_nlp)
  );

  ms_interval_timer #(.W(TW)) u_rx_window (
    .clock   (clock),
    .rstn    (rstn),
    .tick    (tick_r),
    .run     (armed_r),
    .limit   (rx_iv),
    .expired (rx_expired)
  );

  ms_interval_timer #(.W(TW)) u_energy_timer (
    .clock   (clock),
    .rstn    (rstn),
    .tick    (tick_r),
    .run     (!energy_s2_r),
    .limit   (phy_mode_pkg::ENERGY_TIMEOUT_MS),
    .expired (energy_expired)
  );

  // wake detection; a pulse in the window's last cycle still counts
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      armed_r    <= 1'b0;
      sleep_wake <= 1'b0;
    end else begin
      sleep_wake <= 1'b0;
      if (!sleep_en_r) begin
        armed_r <= 1'b0;
      end else if (rx_nlp) begin
        if (cfg_r[phy_mode_pkg::B_SINGLE_WAKE]) begin
          sleep_wake <= 1'b1; // RULE3
        end else if (armed_r) begin
          sleep_wake <= 1'b1; // RULE4
          armed_r    <= 1'b0;
        end else begin
          armed_r <= 1'b1;
        end
      end else if (rx_expired) begin
        armed_r <= 1'b0;
      end
    end
  end

  // registered controls; echo honours isolate by not looking at it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctrl            <= '0;
      xover_extend_ms <= phy_mode_pkg::XOVER_NONE_MS;
    end else begin
      ctrl.sleep_mode_enable     <= sleep_en_r;
      ctrl.green_ethernet_enable <= cfg_r[phy_mode_pkg::B_GREEN]; // RULE5
      ctrl.remote_echo_enable    <= echo_r && if_kind_r; // RULE9
      ctrl.alternate_irq_select  <= alt_irq_r;
      ctrl.interface_kind        <= if_kind_r;
      ctrl.xcvr_mode             <= mode_r;
      ctrl.station_address       <= addr_r;
      if (sleep_en_r && cfg_r[phy_mode_pkg::B_XOVER_SLEEP]) begin
        xover_extend_ms <= phy_mode_pkg::XOVER_SLEEP_MS; // RULE6
      end else if (auto_mdix_en && speed_forced && cfg_r[phy_mode_pkg::B_XOVER_MAN]) begin
        xover_extend_ms <= phy_mode_pkg::XOVER_MANUAL_MS; // RULE7
      end else begin
        xover_extend_ms <= phy_mode_pkg::XOVER_NONE_MS;
      end
    end
  end

  a_tx_pulse_gate: assert property (@(posedge clock) disable iff (!rstn) // RULE1
    tx_nlp |-> $past(sleep_en_r && cfg_r[phy_mode_pkg::B_TX_NLP_EN], 2))
    else $error("link pulse sent outside enabled sleep");
  a_tx_off_quiet: assert property (@(posedge clock) disable iff (!rstn) // RULE1
    (!sleep_en_r) [*3] |-> !tx_nlp)
    else $error("link pulse while sleep off");
  a_single_wake: assert property (@(posedge clock) disable iff (!rstn) // RULE3
    (rx_nlp && sleep_en_r && cfg_r[phy_mode_pkg::B_SINGLE_WAKE]) |=> sleep_wake)
    else $error("single pulse did not wake");
  a_double_wake: assert property (@(posedge clock) disable iff (!rstn) // RULE4
    (rx_nlp && sleep_en_r && !cfg_r[phy_mode_pkg::B_SINGLE_WAKE] && !armed_r) |=> !sleep_wake)
    else $error("first of two pulses woke");
  a_green_follow: assert property (@(posedge clock) disable iff (!rstn) // RULE5
    (wr_cfg && !soft_reset) |=> ##1 ctrl.green_ethernet_enable == $past(req.wdata[phy_mode_pkg::B_GREEN], 2))
    else $error("green enable did not follow write");
  a_xover_sleep: assert property (@(posedge clock) disable iff (!rstn) // RULE6
    (sleep_en_r && cfg_r[phy_mode_pkg::B_XOVER_SLEEP]) |=> xover_extend_ms == phy_mode_pkg::XOVER_SLEEP_MS)
    else $error("sleep crossover extension wrong");
  a_xover_manual: assert property (@(posedge clock) disable iff (!rstn) // RULE7
    (!sleep_en_r && auto_mdix_en && speed_forced && cfg_r[phy_mode_pkg::B_XOVER_MAN])
      |=> xover_extend_ms == phy_mode_pkg::XOVER_MANUAL_MS)
    else $error("manual crossover extension wrong");
  a_sleep_write: assert property (@(posedge clock) disable iff (!rstn) // RULE8
    (wr_mode && !soft_reset) |=> sleep_en_r == $past(req.wdata[phy_mode_pkg::B_SLEEP_EN]))
    else $error("sleep enable did not follow write");
  a_echo_reduced: assert property (@(posedge clock) disable iff (!rstn) // RULE9
    ctrl.remote_echo_enable |-> $past(if_kind_r && echo_r))
    else $error("echo enabled outside reduced mode");
  a_energy_hold: assert property (@(posedge clock) disable iff (!rstn) // RULE11
    (soft_reset && energy_r && !energy_expired) |=> energy_r)
    else $error("soft reset disturbed energy bit");
  a_reserved_zero: assert property (@(posedge clock) disable iff (!rstn) // RULE15
    (req.rd && req.addr == phy_mode_pkg::ADDR_SLEEP_CFG) |=> rdata[9:3] == 7'h00)
    else $error("reserved bits read nonzero");
endmodule

// ==== sim/smi_master_model.sv ====
// management controller model issuing register reads and writes
`timescale 1ns/1ps
module smi_master_model (
  input  wire logic              clock,
  output phy_mode_pkg::reg_req_t req
);
  logic [15:0] exp_q[$];

  initial req = '0;

  // released lines show the inverse so a stale value never passes
  task automatic release_bus(input logic [4:0] a, input logic [15:0] d);
    req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clock);
    release_bus(a, d);
  endtask

  // the expected word is noted before the request goes out
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(negedge clock);
    exp_q.push_back(e);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 16'h0000};
    @(negedge clock);
    release_bus(a, 16'h0000);
  endtask
endmodule

// ==== sim/test_phy_power_mode_config_regs.sv ====
// self-checking bench for the power and mode configuration registers
`timescale 1ns/1ps
module test_phy_power_mode_config_regs;
  localparam int MSC = 4;
  logic                   clock;
  logic                   rstn;
  logic                   soft_reset;
  phy_mode_pkg::reg_req_t req;
  logic [15:0]            rdata;
  logic                   rvalid;
  logic                   energy_pin;
  logic                   rx_nlp;
  logic                   auto_mdix_en;
  logic                   speed_forced;
  phy_mode_pkg::ctrl_t    ctrl;
  logic                   tx_nlp;
  logic                   sleep_wake;
  logic [11:0]            xover_extend_ms;
  int                     fail_count = 0;
  int                     compares = 0;
  int                     cyc = 0;
  int                     seed = 43;
  int                     ivt[4] = '{1000, 768, 512, 256};
  int                     t0;
  logic [15:0]            d;
  logic                   strap_if = 1'b1;
  logic [2:0]             strap_mode = 3'h5;
  logic [4:0]             strap_addr = 5'h0a;

  smi_master_model u_mac (.clock(clock), .req(req));

  phy_power_mode_config_regs #(.MS_CYCLES(MSC)) u_dut (
    .clock(clock), .rstn(rstn), .soft_reset(soft_reset), .req(req),
    .rdata(rdata), .rvalid(rvalid), .energy_pin(energy_pin), .rx_nlp(rx_nlp),
    .auto_mdix_en(auto_mdix_en), .speed_forced(speed_forced),
    .reduced_interface_strap(strap_if), .mode_strap(strap_mode), .address_strap(strap_addr),
    .ctrl(ctrl), .tx_nlp(tx_nlp), .sleep_wake(sleep_wake),
    .xover_extend_ms(xover_extend_ms)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_ctrl(input logic [15:0] exp);
    @(negedge clock);
    @(negedge clock);
    chk({3'h0, ctrl}, exp);
  endtask

  task automatic chk_xover(input logic [11:0] exp);
    chk({4'h0, xover_extend_ms}, {4'h0, exp});
  endtask

  // read results are taken off the queue as they appear
  always @(negedge clock) begin
    if (rvalid === 1'b1) begin
      if (u_mac.exp_q.size() == 0) begin
        chk(rdata, 16'hdead);
      end else begin
        chk(rdata, u_mac.exp_q.pop_front());
      end
    end
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fail_count++;
      results();
    end
  end

  task automatic wait_tx();
    for (int i = 0; i < 5000 && tx_nlp !== 1'b1; i++) @(negedge clock);
    chk({15'h0, tx_nlp}, 16'h0001);
    t0 = cyc;
    @(negedge clock);
  endtask

  task automatic nlp_in(input logic exp);
    @(negedge clock);
    rx_nlp = 1'b1;
    @(negedge clock);
    rx_nlp = 1'b0;
    // the wake pulse stands for one cycle only, so look right away
    chk({15'h0, sleep_wake}, {15'h0, exp});
  endtask

  initial begin
    rstn = 1'b0;
    soft_reset = 1'b0;
    energy_pin = 1'b1;
    rx_nlp = 1'b0;
    auto_mdix_en = 1'b1;
    speed_forced = 1'b1;
    repeat (8) @(negedge clock);
    rstn = 1'b1;
    repeat (6) @(negedge clock);
    u_mac.rd(5'h10, 16'h0001);
    u_mac.rd(5'h11, 16'h0002);
    u_mac.rd(5'h12, 16'h40aa);
    chk_ctrl(16'h01aa);
    chk_xover(12'h7c0);
    u_mac.wr(5'h10, 16'hffff);
    u_mac.rd(5'h10, 16'hfc07);
    chk_ctrl(16'h09aa);
    chk_xover(12'h7c0);
    u_mac.wr(5'h10, 16'h0000);
    chk_ctrl(16'h01aa);
    chk_xover(12'h000);
    u_mac.wr(5'h10, 16'h0001);
    speed_forced = 1'b0;
    chk_ctrl(16'h01aa);
    chk_xover(12'h000);
    speed_forced = 1'b1;
    u_mac.wr(5'h11, 16'hffff);
    u_mac.rd(5'h11, 16'h2243);
    chk_ctrl(16'h17aa);
    chk_xover(12'h7c0);
    u_mac.wr(5'h10, 16'h0002);
    chk_ctrl(16'h17aa);
    chk_xover(12'hba0);
    @(negedge clock);
    soft_reset = 1'b1;
    @(negedge clock);
    soft_reset = 1'b0;
    u_mac.rd(5'h11, 16'h0002);
    u_mac.rd(5'h10, 16'h0002);
    chk_ctrl(16'h01aa);
    u_mac.wr(5'h12, 16'hffff);
    u_mac.rd(5'h12, 16'h40ff);
    u_mac.rd(5'h13, 16'h0000);
    chk_ctrl(16'h01ff);
    for (int i = 0; i < 8; i++) begin
      d = 16'($random(seed));
      u_mac.wr(5'h10, d);
      u_mac.rd(5'h10, d & 16'hfc07);
    end
    // interval measured between later pulses so the enable phase drops out
    u_mac.wr(5'h11, 16'h2000);
    for (int c = 0; c < 4; c++) begin
      u_mac.wr(5'h10, {1'b1, 2'(c), 13'h0000});
      wait_tx();
      wait_tx();
      d = 16'(t0);
      wait_tx();
      chk(16'(t0) - d, 16'(ivt[c] * MSC));
    end
    u_mac.wr(5'h10, 16'h6000);
    d = 16'h0000;
    repeat (1100) begin
      @(negedge clock);
      if (tx_nlp === 1'b1) d++;
    end
    chk(d, 16'h0000);
    u_mac.wr(5'h10, 16'h1000);
    nlp_in(1'b1);
    u_mac.wr(5'h10, 16'h0000);
    nlp_in(1'b0);
    repeat (50) @(negedge clock);
    nlp_in(1'b1);
    repeat (400) @(negedge clock);
    nlp_in(1'b0);
    repeat (400) @(negedge clock);
    nlp_in(1'b0);
    energy_pin = 1'b0;
    repeat (256 * MSC - 20) @(negedge clock);
    u_mac.rd(5'h11, 16'h2002);
    repeat (40) @(negedge clock);
    u_mac.rd(5'h11, 16'h2000);
    energy_pin = 1'b1;
    repeat (6) @(negedge clock);
    u_mac.rd(5'h11, 16'h2002);
    repeat (4) @(negedge clock);
    // second hardware reset with other straps: full interface blocks the echo
    rstn = 1'b0;
    strap_if = 1'b0;
    strap_mode = 3'h2;
    strap_addr = 5'h13;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    repeat (6) @(negedge clock);
    u_mac.rd(5'h12, 16'h0053);
    u_mac.wr(5'h11, 16'h0200);
    u_mac.rd(5'h11, 16'h0202);
    chk_ctrl(16'h0053);
    chk_xover(12'h7c0);
    repeat (4) @(negedge clock);
    chk(16'(u_mac.exp_q.size()), 16'h0000);
    results();
  end
endmodule
